// >>> inc/asc_pkg.sv
// constants shared by the converter scan and trigger controller
`default_nettype none
package asc_pkg;
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned CONV_MAX_HZ  = 4_500_000;
    // least divide that keeps the converter rate at or below its ceiling
    localparam int unsigned CONV_MIN_DIV = (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
    localparam int unsigned NUM_CHAN     = 8;
    localparam int unsigned CHAN_W       = 3;
    localparam int unsigned RES_W        = 10;
    localparam int unsigned NUM_START    = 4;
    localparam int unsigned DIV_W        = 8;
    localparam logic [3:0] RES_MIN       = 4'h2;
    localparam logic [3:0] RES_MAX       = 4'hA;
    localparam logic [3:0] RES_RST       = 4'hA;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h17;
    // starts sampled every system cycle; the others only on converter ticks
    localparam logic [3:0] START_SYS_MASK = 4'h5;
    localparam logic [RES_W-1:0] CODE_MSB = 10'h200;
    typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONV} asc_state_t;
endpackage
`default_nettype wire

// >>> hdl/asc_adc_scan_trigger_control.sv
// converter scan sequencer, trigger selection, results and threshold compare
`default_nettype none
module asc_adc_scan_trigger_control
    import asc_pkg::*;
(
    input  wire logic                      core_clk_i,       // system clock
    input  wire logic                      reset_n_i,        // async reset
    input  wire logic [DIV_W-1:0]          cfg_div_i,        // converter clock divide
    input  wire logic [3:0]                cfg_res_i,        // resolution in bits
    input  wire logic                      cfg_continuous_i, // continuous scan
    input  wire logic [NUM_CHAN-1:0]       cfg_chan_en_i,    // channels in scan
    input  wire logic [NUM_START-1:0]      cfg_start_en_i,   // start input enables
    input  wire logic [NUM_START-1:0]      cfg_start_rise_i, // 1 rising, 0 falling
    input  wire logic [NUM_CHAN-1:0]       cfg_cmp_en_i,     // compare enables
    input  wire logic [NUM_CHAN*RES_W-1:0] cfg_cmp_val_i,    // compare values
    input  wire logic                      cfg_update_i,     // transfer staged config
    input  wire logic                      sw_start_i,       // software start pulse
    input  wire logic                      sw_stop_i,        // end continuous scan
    input  wire logic [NUM_START-1:0]      scan_start_i,     // trigger inputs
    input  wire logic                      sar_cmp_i,        // analog comparator
    output logic                           conv_tick_o,      // converter clock enable
    output logic                           sample_o,         // sample phase
    output logic [CHAN_W-1:0]              chan_o,           // multiplexer select
    output logic [RES_W-1:0]               dac_code_o,       // trial code
    output logic [NUM_CHAN*RES_W-1:0]      result_o,         // per-channel results
    output logic [NUM_CHAN-1:0]            cmp_below_o,      // below threshold
    output logic [NUM_CHAN-1:0]            cmp_above_o,      // at or above threshold
    output logic                           busy_o,           // scan running
    output logic                           scan_done_o,      // scan end pulse
    output logic                           start_capture_o,  // scan start pulse
    output logic                           cfg_pending_o     // update not yet taken
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [3:0] first_from(input logic [NUM_CHAN-1:0] mask,
                                              input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_CHAN - 1; i >= 0; i--)
        begin
            if (mask[i] && (4'(i) >= from))
            begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [RES_W-1:0] bit_of(input logic [3:0] idx);
        return RES_W'(1) << idx;
    endfunction

    // ************************************************************
    // active configuration
    // ************************************************************
    logic [DIV_W-1:0]          act_div_q;
    logic [3:0]                act_res_q;
    logic                      act_cont_q;
    logic [NUM_CHAN-1:0]       act_chan_q;
    logic [NUM_START-1:0]      act_start_en_q;
    logic [NUM_START-1:0]      act_rise_q;
    logic [NUM_CHAN-1:0]       act_cmp_en_q;
    logic [NUM_CHAN*RES_W-1:0] act_cmp_val_q;
    logic                      cfg_pend_q;
    logic                      tick_q;
    asc_state_t                state_q;
    asc_state_t                state_d;
    logic                      scan_end_w;
    logic                      apply_w;
    logic [3:0]                res_clamp_w;
    logic [NUM_CHAN-1:0]       scan_mask_w;
    logic                      cont_w;

    assign res_clamp_w = (cfg_res_i < RES_MIN) ? RES_MIN :
                         (cfg_res_i > RES_MAX) ? RES_MAX : cfg_res_i;
    assign apply_w     = cfg_pend_q && tick_q && (state_q == ASC_IDLE || scan_end_w);
    // a scan started on the transfer tick already follows the new set
    assign scan_mask_w = apply_w ? cfg_chan_en_i : act_chan_q;
    assign cont_w      = apply_w ? cfg_continuous_i : act_cont_q;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cfg_pend_q <= 1'b0;
        end
        else
        begin
            cfg_pend_q <= cfg_update_i || (cfg_pend_q && !apply_w);
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            act_div_q      <= DIV_RST;
            act_res_q      <= RES_RST;
            act_cont_q     <= 1'b0;
            act_chan_q     <= '0;
            act_start_en_q <= '0;
            act_rise_q     <= '0;
            act_cmp_en_q   <= '0;
            act_cmp_val_q  <= '0;
        end
        else if (apply_w)
        begin
            act_div_q      <= cfg_div_i;
            act_res_q      <= res_clamp_w;
            act_cont_q     <= cfg_continuous_i;
            act_chan_q     <= cfg_chan_en_i;
            act_start_en_q <= cfg_start_en_i;
            act_rise_q     <= cfg_start_rise_i;
            act_cmp_en_q   <= cfg_cmp_en_i;
            act_cmp_val_q  <= cfg_cmp_val_i;
        end
    end

    // ************************************************************
    // converter clock enable
    // ************************************************************
    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_load_w;

    assign div_load_w = (act_div_q < DIV_W'(CONV_MIN_DIV)) ?
                        DIV_W'(CONV_MIN_DIV - 1) : act_div_q - DIV_W'(1);

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_cnt_q <= '0;
            tick_q    <= 1'b0;
        end
        else
        begin
            div_cnt_q <= (div_cnt_q == '0) ? div_load_w : div_cnt_q - DIV_W'(1);
            tick_q    <= (div_cnt_q == '0);
        end
    end

    // ************************************************************
    // start inputs
    // ************************************************************
    logic [NUM_START-1:0] st_s1_q;
    logic [NUM_START-1:0] st_s2_q;
    logic [NUM_START-1:0] st_prev_q;
    logic [NUM_START-1:0] st_samp_w;
    logic [NUM_START-1:0] st_edge_w;
    logic                 cmp_s1_q;
    logic                 cmp_s2_q;
    logic                 start_pend_q;
    logic                 stop_pend_q;
    logic                 kick_w;

    assign st_samp_w = START_SYS_MASK | {NUM_START{tick_q}};
    assign st_edge_w = st_samp_w & act_start_en_q &
                       ((act_rise_q & st_s2_q & ~st_prev_q) |
                        (~act_rise_q & ~st_s2_q & st_prev_q));
    assign kick_w    = tick_q && state_q == ASC_IDLE && start_pend_q && |scan_mask_w;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_s1_q      <= '0;
            st_s2_q      <= '0;
            st_prev_q    <= '0;
            cmp_s1_q     <= 1'b0;
            cmp_s2_q     <= 1'b0;
            start_pend_q <= 1'b0;
            stop_pend_q  <= 1'b0;
        end
        else
        begin
            st_s1_q      <= scan_start_i;
            st_s2_q      <= st_s1_q;
            st_prev_q    <= (st_s2_q & st_samp_w) | (st_prev_q & ~st_samp_w);
            cmp_s1_q     <= sar_cmp_i;
            cmp_s2_q     <= cmp_s1_q;
            // a start arriving as the pending one is taken is kept
            start_pend_q <= (|st_edge_w) || sw_start_i || (start_pend_q && !kick_w);
            stop_pend_q  <= sw_stop_i || (stop_pend_q && !kick_w);
        end
    end

    // ************************************************************
    // scan sequencer
    // ************************************************************
    logic [CHAN_W-1:0] chan_q;
    logic [CHAN_W-1:0] chan_d;
    logic [RES_W-1:0]  code_q;
    logic [RES_W-1:0]  code_d;
    logic [3:0]        bit_q;
    logic [3:0]        bit_d;
    logic [3:0]        lsb_w;
    logic [RES_W-1:0]  code_dec_w;
    logic              fin_w;
    logic [3:0]        next_w;
    logic [3:0]        first_w;
    logic [RES_W-1:0]  val_w;
    logic              above_w;

    assign lsb_w      = RES_MAX - act_res_q;
    assign code_dec_w = cmp_s2_q ? code_q : code_q & ~bit_of(bit_q);
    assign fin_w      = tick_q && state_q == ASC_CONV && bit_q == lsb_w;
    assign next_w     = first_from(act_chan_q, 4'(chan_q) + 4'h1);
    assign first_w    = first_from(scan_mask_w, 4'h0);
    assign scan_end_w = fin_w && !next_w[3];
    assign val_w      = act_cmp_val_q[chan_q*RES_W +: RES_W];
    assign above_w    = code_dec_w >= val_w;

    always_comb
    begin
        state_d = state_q;
        chan_d  = chan_q;
        code_d  = code_q;
        bit_d   = bit_q;
        if (tick_q)
        begin
            unique case (state_q)
                ASC_IDLE:
                begin
                    if (kick_w)
                    begin
                        state_d = ASC_SAMPLE;
                        chan_d  = first_w[CHAN_W-1:0];
                    end
                end
                ASC_SAMPLE:
                begin
                    state_d = ASC_CONV;
                    code_d  = CODE_MSB;
                    bit_d   = RES_MAX - 4'h1;
                end
                ASC_CONV:
                begin
                    if (bit_q != lsb_w)
                    begin
                        code_d = code_dec_w | bit_of(bit_q - 4'h1);
                        bit_d  = bit_q - 4'h1;
                    end
                    else if (next_w[3])
                    begin
                        state_d = ASC_SAMPLE;
                        chan_d  = next_w[CHAN_W-1:0];
                    end
                    else if (cont_w && !stop_pend_q && first_w[3])
                    begin
                        state_d = ASC_SAMPLE;
                        chan_d  = first_w[CHAN_W-1:0];
                    end
                    else
                    begin
                        state_d = ASC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= ASC_IDLE;
            chan_q  <= '0;
            code_q  <= '0;
            bit_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            chan_q  <= chan_d;
            code_q  <= code_d;
            bit_q   <= bit_d;
        end
    end

    // ************************************************************
    // results, compare and outputs
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            result_o    <= '0;
            cmp_below_o <= '0;
            cmp_above_o <= '0;
        end
        else if (fin_w)
        begin
            result_o[chan_q*RES_W +: RES_W] <= code_dec_w;
            cmp_above_o[chan_q] <= act_cmp_en_q[chan_q] && above_w;
            cmp_below_o[chan_q] <= act_cmp_en_q[chan_q] && !above_w;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            conv_tick_o     <= 1'b0;
            sample_o        <= 1'b0;
            chan_o          <= '0;
            dac_code_o      <= '0;
            busy_o          <= 1'b0;
            scan_done_o     <= 1'b0;
            start_capture_o <= 1'b0;
            cfg_pending_o   <= 1'b0;
        end
        else
        begin
            conv_tick_o     <= tick_q;
            sample_o        <= state_d == ASC_SAMPLE;
            chan_o          <= chan_d;
            dac_code_o      <= code_d;
            busy_o          <= state_d != ASC_IDLE;
            scan_done_o     <= scan_end_w;
            start_capture_o <= kick_w;
            cfg_pending_o   <= cfg_update_i || (cfg_pend_q && !apply_w);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [4:0] hlp_ticks_q;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            hlp_ticks_q <= '0;
        end
        else if (tick_q)
        begin
            hlp_ticks_q <= (state_d == ASC_SAMPLE) ? 5'h0 : hlp_ticks_q + 5'h1;
        end
    end

    sequence s_quiet;
        !tick_q [*8];
    endsequence

    sequence s_kick;
        tick_q && state_q == ASC_IDLE && start_pend_q && |scan_mask_w;
    endsequence

    AST_TICK_SPACING: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        tick_q |=> s_quiet) else $error("converter tick too frequent");
    AST_CONV_LENGTH: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        fin_w |-> hlp_ticks_q == 5'(act_res_q)) else $error("conversion length wrong");
    AST_RES_RANGE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        act_res_q >= RES_MIN && act_res_q <= RES_MAX) else $error("resolution out of range");
    AST_CHAN_ENABLED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state_q != ASC_IDLE |-> act_chan_q[chan_q]) else $error("disabled channel converted");
    AST_CFG_HELD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $changed(act_res_q) |-> $past(cfg_pend_q) && $past(tick_q))
        else $error("config changed without update");
    AST_START_KICK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_kick |=> sample_o && busy_o && start_capture_o) else $error("start not taken");
    AST_SLOW_START: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $changed(st_prev_q[1]) || $changed(st_prev_q[3]) |-> $past(tick_q))
        else $error("converter-side start sampled off tick");
    AST_RESULT_STORE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        fin_w |=> result_o[$past(chan_q)*RES_W +: RES_W] == $past(code_dec_w))
        else $error("result not stored");
    AST_CMP_FLAG: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        fin_w && act_cmp_en_q[chan_q] |=> cmp_above_o[$past(chan_q)] == $past(above_w)
        && cmp_below_o[$past(chan_q)] != cmp_above_o[$past(chan_q)])
        else $error("compare flag wrong");
    AST_SINGLE_END: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        scan_end_w && !cont_w |=> !busy_o) else $error("single scan did not stop");

endmodule
`default_nettype wire

// >>> sim/asc_sar_model.sv
// behavioural analog core: multiplexer and comparator against channel levels
`default_nettype none
module asc_sar_model
    import asc_pkg::*;
(
    input  wire logic [NUM_CHAN*RES_W-1:0] vin_i,  // channel levels as codes
    input  wire logic [CHAN_W-1:0]         chan_i, // multiplexer select
    input  wire logic [RES_W-1:0]          code_i, // trial code
    output logic                           cmp_o   // level at or above code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RES_W-1:0] level;
    assign level = vin_i[chan_i*RES_W +: RES_W];
    assign cmp_o = (level >= code_i);
endmodule
`default_nettype wire

// >>> sim/asc_adc_scan_trigger_control_tb.sv
// self-checking bench for the converter scan and trigger controller
`default_nettype none
module asc_adc_scan_trigger_control_tb
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [79:0] VIN = {10'h37C, 10'h0C3, 10'h2AA, 10'h155,
                                   10'h1FF, 10'h200, 10'h000, 10'h3FF};
    logic        core_clk_i, reset_n_i, cfg_continuous, cfg_update, sw_start, sw_stop;
    logic [7:0]  cfg_div, cfg_chan_en, cfg_cmp_en, cmp_below, cmp_above;
    logic [3:0]  cfg_res, cfg_start_en, cfg_start_rise, scan_start;
    logic [79:0] cfg_cmp_val, result;
    logic        sar_cmp, conv_tick, sample, busy, scan_done, start_capture, cfg_pending;
    logic [2:0]  chan;
    logic [9:0]  dac_code;
    int          fails, n_compared;

    asc_adc_scan_trigger_control dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cfg_div_i(cfg_div),
        .cfg_res_i(cfg_res), .cfg_continuous_i(cfg_continuous), .cfg_chan_en_i(cfg_chan_en),
        .cfg_start_en_i(cfg_start_en), .cfg_start_rise_i(cfg_start_rise),
        .cfg_cmp_en_i(cfg_cmp_en), .cfg_cmp_val_i(cfg_cmp_val), .cfg_update_i(cfg_update),
        .sw_start_i(sw_start), .sw_stop_i(sw_stop), .scan_start_i(scan_start),
        .sar_cmp_i(sar_cmp), .conv_tick_o(conv_tick), .sample_o(sample), .chan_o(chan),
        .dac_code_o(dac_code), .result_o(result), .cmp_below_o(cmp_below),
        .cmp_above_o(cmp_above), .busy_o(busy), .scan_done_o(scan_done),
        .start_capture_o(start_capture), .cfg_pending_o(cfg_pending));

    asc_sar_model analog (.vin_i(VIN), .chan_i(chan), .code_i(dac_code), .cmp_o(sar_cmp));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // waits for start_capture_o (0) or scan_done_o (1) within a bound
    task automatic wait_hi(input int which, input int lim);
        int k;
        k = 0;
        while (((which == 0) ? start_capture : scan_done) !== 1'b1 && k < lim)
        begin
            cyc(1);
            k++;
        end
        chk(which == 0 ? "start_capture_o" : "scan_done_o", 1,
            (which == 0) ? start_capture : scan_done);
    endtask

    task automatic quiet(input int n);
        int k;
        k = 0;
        repeat (n)
        begin
            if (start_capture === 1'b1) k++;
            cyc(1);
        end
        chk("unwanted starts", 0, k);
    endtask

    // transfer staged set and wait until taken
    task automatic upd();
        int k;
        k = 0;
        cfg_update = 1'b1;
        cyc(1);
        cfg_update = 1'b0;
        cyc(1);
        while (cfg_pending !== 1'b0 && k < 80)
        begin
            cyc(1);
            k++;
        end
        chk("cfg_pending_o", 0, cfg_pending);
    endtask

    task automatic pulse_start();
        sw_start = 1'b1;
        cyc(1);
        sw_start = 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_stage();
        cfg_chan_en = 8'h01;
        pulse_start();
        cyc(100);
        chk("busy_o before transfer", 0, busy);
        upd();
        wait_hi(0, 60);
        wait_hi(1, 400);
    endtask

    task automatic run_scan(input logic [7:0] div, input logic [3:0] res,
                            input logic [7:0] chen, input logic [7:0] cmpen,
                            input logic [79:0] cval);
        int n, t, ticks, deff;
        logic [9:0] m, e;
        deff = (div < 8'h17) ? 23 : int'(div);
        n = $countones(chen);
        cfg_div = div;
        cfg_res = res;
        cfg_chan_en = chen;
        cfg_cmp_en = cmpen;
        cfg_cmp_val = cval;
        upd();
        pulse_start();
        wait_hi(0, 2 * deff + 5);
        e = 10'h0;
        for (int c = 7; c >= 0; c--)
        begin
            if (chen[c])
            begin
                e = 10'(c);
            end
        end
        chk("chan_o at start", e, chan);
        chk("sample_o at start", 1, sample);
        t = 0;
        ticks = 0;
        cyc(1);
        while (scan_done !== 1'b1 && t < 12000)
        begin
            if (conv_tick === 1'b1) ticks++;
            cyc(1);
            t++;
        end
        if (conv_tick === 1'b1) ticks++;
        chk("scan cycles", n * (int'(res) + 1) * deff, t + 1);
        chk("conv ticks", n * (int'(res) + 1), ticks);
        cyc(2);
        chk("busy_o after single", 0, busy);
        m = 10'h3FF << (10 - int'(res));
        for (int c = 0; c < 8; c++)
        begin
            if (chen[c])
            begin
                e = VIN[c*10 +: 10] & m;
                chk("result_o", e, result[c*10 +: 10]);
                chk("cmp_above_o", cmpen[c] && e >= cval[c*10 +: 10], cmp_above[c]);
                chk("cmp_below_o", cmpen[c] && e < cval[c*10 +: 10], cmp_below[c]);
            end
        end
    endtask

    task automatic s_cont();
        cfg_continuous = 1'b1;
        cfg_chan_en = 8'h02;
        cfg_res = 4'h3;
        cfg_div = 8'h17;
        upd();
        pulse_start();
        wait_hi(1, 300);
        cyc(1);
        wait_hi(1, 200);
        cfg_res = 4'h2;
        cfg_update = 1'b1;
        cyc(1);
        cfg_update = 1'b0;
        cyc(2);
        chk("cfg_pending_o held", 1, cfg_pending);
        sw_stop = 1'b1;
        cyc(1);
        sw_stop = 1'b0;
        wait_hi(1, 200);
        cyc(3);
        chk("cfg_pending_o at end", 0, cfg_pending);
        chk("busy_o after stop", 0, busy);
        quiet(150);
        cfg_continuous = 1'b0;
    endtask

    task automatic s_trig();
        cfg_chan_en = 8'h01;
        cfg_res = 4'h2;
        cfg_cmp_en = 8'h00;
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cfg_start_en = 4'h1 << i;
                cfg_start_rise = (p == 0) ? 4'hF : 4'h0;
                upd();
                scan_start[i] = 1'b1;
                if (p == 0)
                begin
                    wait_hi(0, 60);
                    wait_hi(1, 200);
                end
                else quiet(80);
                scan_start[i] = 1'b0;
                if (p == 0) quiet(80);
                else
                begin
                    wait_hi(0, 60);
                    wait_hi(1, 200);
                end
            end
        end
        cfg_start_en = 4'h0;
    endtask

    // ************************************************************
    // run
    // ************************************************************
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        #400_000;
        fails++;
        $display("MISMATCH watchdog expected done seen hang");
        results();
    end

    initial
    begin
        fails = 0;
        n_compared = 0;
        reset_n_i = 1'b0;
        cfg_div = 8'h17;
        cfg_res = 4'hA;
        cfg_continuous = 1'b0;
        cfg_chan_en = 8'h00;
        cfg_start_en = 4'h0;
        cfg_start_rise = 4'hF;
        cfg_cmp_en = 8'h00;
        cfg_cmp_val = 80'h0;
        cfg_update = 1'b0;
        sw_start = 1'b0;
        sw_stop = 1'b0;
        scan_start = 4'h0;
        cyc(2);
        chk("result_o in reset", 0, result);
        chk("outputs in reset", 0, {cmp_below, cmp_above, busy, scan_done, start_capture,
            cfg_pending, conv_tick, sample, chan, dac_code});
        reset_n_i = 1'b1;
        s_stage();
        run_scan(8'h1E, 4'hA, 8'h89, 8'h88, {10'h37D, 30'h0, 10'h1FF, 30'h0});
        chk("unconverted result", 0, result[10 +: 10]);
        run_scan(8'h05, 4'h2, 8'hFF, 8'hFF, {8{10'h200}});
        run_scan(8'h17, 4'h5, 8'h24, 8'h04, {8{10'h2A0}});
        s_cont();
        s_trig();
        results();
    end
endmodule
`default_nettype wire
